// ### design/iwdec_regs.svh
// Constants for the instruction word decoder: field positions, widths, reset values, timing
`ifndef IWDEC_REGS_SVH
`define IWDEC_REGS_SVH

`define IWDEC_WORD_W 14
`define IWDEC_ADDR_W 7
`define IWDEC_BITSEL_W 3
`define IWDEC_LIT8_W 8
`define IWDEC_LIT11_W 11
`define IWDEC_OPC_W 6
`define IWDEC_GROUP_HI 13
`define IWDEC_GROUP_LO 12
`define IWDEC_BYTEOP_HI 11
`define IWDEC_BYTEOP_LO 8
`define IWDEC_DEST_BIT 7
`define IWDEC_ADDR_HI 6
`define IWDEC_BITOP_HI 11
`define IWDEC_BITOP_LO 10
`define IWDEC_BITSEL_HI 9
`define IWDEC_BITSEL_LO 7
`define IWDEC_JUMP_BIT 11
`define IWDEC_GROUP_BYTE 2'h0
`define IWDEC_GROUP_BIT 2'h1
`define IWDEC_GROUP_BRANCH 2'h2
`define IWDEC_GROUP_LIT 2'h3
`define IWDEC_BYTEOP_MISC 4'h0
`define IWDEC_BYTEOP_DEC_SKIP 4'hB
`define IWDEC_BYTEOP_INC_SKIP 4'hF
`define IWDEC_BITOP_SKIPCLR 2'h2
`define IWDEC_BITOP_SKIPSET 2'h3
`define IWDEC_LITOP_RETLIT_HI 2'h1
`define IWDEC_MISC_RETURN 8'h08
`define IWDEC_MISC_RETURN_IRQ 8'h09
`define IWDEC_PHASES 4
`define IWDEC_PHASE_W 2
`define IWDEC_PHASE_RESET 2'h0
`define IWDEC_PHASE_LAST 2'h3

`endif

// ### design/iwdec_pkg.sv
// Types shared by the instruction word decoder modules
`include "iwdec_regs.svh"
package iwdec_pkg;
	typedef enum logic [1:0] {IWDEC_CLASS_BYTE, IWDEC_CLASS_BIT, IWDEC_CLASS_LIT} iwdec_class_t;
	typedef struct packed {
		iwdec_class_t op_class;
		logic is_branch;
		logic is_call;
		logic is_return;
		logic is_skip_test;
		logic skip_on_set;
		logic dest_file;
		logic [`IWDEC_OPC_W-1:0] opcode;
		logic [`IWDEC_ADDR_W-1:0] file_addr;
		logic [`IWDEC_BITSEL_W-1:0] bit_sel;
		logic [`IWDEC_LIT8_W-1:0] lit8;
		logic [`IWDEC_LIT11_W-1:0] lit11;
	} iwdec_fields_t;
	typedef enum {IWDEC_ST_EXEC, IWDEC_ST_FLUSH} iwdec_state_t;
endpackage : iwdec_pkg

// ### design/iwdec_field_split.sv
// Combinational split of one instruction word into class and operand fields
`timescale 1ns/1ns
`default_nettype none
`include "iwdec_regs.svh"
module iwdec_field_split import iwdec_pkg::*; (
	input wire logic [`IWDEC_WORD_W-1:0] i_word,
	output iwdec_fields_t o_fields
);
	logic [1:0] grp;
	logic [3:0] byteop;
	logic [1:0] bitop;
	always_comb begin
		grp = i_word[`IWDEC_GROUP_HI:`IWDEC_GROUP_LO];
		byteop = i_word[`IWDEC_BYTEOP_HI:`IWDEC_BYTEOP_LO];
		bitop = i_word[`IWDEC_BITOP_HI:`IWDEC_BITOP_LO];
		o_fields = '0;
		o_fields.opcode = i_word[`IWDEC_WORD_W-1:`IWDEC_WORD_W-`IWDEC_OPC_W];
		o_fields.file_addr = i_word[`IWDEC_ADDR_HI:0];
		o_fields.dest_file = i_word[`IWDEC_DEST_BIT];
		o_fields.bit_sel = i_word[`IWDEC_BITSEL_HI:`IWDEC_BITSEL_LO];
		o_fields.lit8 = i_word[`IWDEC_LIT8_W-1:0];
		o_fields.lit11 = i_word[`IWDEC_LIT11_W-1:0];
		// Low bits of don't-care literal opcodes are never examined
		case (grp)
			`IWDEC_GROUP_BYTE: begin
				o_fields.op_class = IWDEC_CLASS_BYTE;
				o_fields.is_skip_test = (byteop == `IWDEC_BYTEOP_DEC_SKIP) || (byteop == `IWDEC_BYTEOP_INC_SKIP);
				o_fields.is_return = (byteop == `IWDEC_BYTEOP_MISC) && !i_word[`IWDEC_DEST_BIT]
					&& ((i_word[`IWDEC_LIT8_W-1:0] == `IWDEC_MISC_RETURN)
					|| (i_word[`IWDEC_LIT8_W-1:0] == `IWDEC_MISC_RETURN_IRQ));
			end
			`IWDEC_GROUP_BIT: begin
				o_fields.op_class = IWDEC_CLASS_BIT;
				o_fields.is_skip_test = (bitop == `IWDEC_BITOP_SKIPCLR) || (bitop == `IWDEC_BITOP_SKIPSET);
				o_fields.skip_on_set = (bitop == `IWDEC_BITOP_SKIPSET);
			end
			`IWDEC_GROUP_BRANCH: begin
				o_fields.op_class = IWDEC_CLASS_LIT;
				o_fields.is_branch = 1'b1;
				o_fields.is_call = !i_word[`IWDEC_JUMP_BIT];
			end
			default: begin
				o_fields.op_class = IWDEC_CLASS_LIT;
				o_fields.is_return = (i_word[`IWDEC_BYTEOP_HI:`IWDEC_BITOP_LO] == `IWDEC_LITOP_RETLIT_HI);
			end
		endcase
	end
endmodule : iwdec_field_split
`default_nettype wire

// ### design/iwdec_core.sv
// Instruction word decoder: field split, phase sequencing and two-cycle flush control
`timescale 1ns/1ns
`default_nettype none
`include "iwdec_regs.svh"
// Behaviour
// - Each instruction arrives as one 14-bit word of opcode plus operand fields.
// - Every word is classed as byte-oriented, bit-oriented or literal and control.
// - Byte-oriented words yield a file register address and a destination select.
// - Destination zero sends the result to the working register, one to the file register.
// - The file register address is seven bits wide, covering 0x00 to 0x7F.
// - Bit-oriented words yield a three-bit bit selector and a file register address.
// - Literal and control words yield an eight-bit data literal or an eleven-bit target.
// - Don't-care positions are ignored so either value decodes the same.
// - An instruction takes one instruction cycle unless a skip is taken or the counter jumps.
// - A taken skip or a jump takes two cycles, the second behaving as a no-operation.
// - One instruction cycle spans four core clock periods.
// - Byte words have 00 on top, a four-bit operation, the destination bit and the address.
// - Bit words have 01 on top, a two-bit operation, the bit selector and the address.
// - Words with 10 on top are call or jump, the next bit picks jump, eleven bits of target.
module iwdec_core import iwdec_pkg::*; (
	input wire logic i_clock,
	input wire logic i_rstn,
	input wire logic [`IWDEC_WORD_W-1:0] i_instr_word,
	input wire logic i_test_true,
	output logic [`IWDEC_PHASE_W-1:0] o_phase,
	output logic o_cycle_start,
	output iwdec_fields_t o_fields,
	output logic o_flush,
	output logic o_pc_change
);
	typedef struct packed {
		logic [`IWDEC_PHASE_W-1:0] phase;
		iwdec_state_t st;
		iwdec_fields_t fields;
		logic flush;
		logic pc_change;
		logic cycle_start;
	} iwdec_state_bundle_t;

	iwdec_state_bundle_t state_r;
	iwdec_state_bundle_t state_nxt;
	iwdec_fields_t split_fields;

	iwdec_field_split u_split (
		.i_word(i_instr_word),
		.o_fields(split_fields)
	);

	function automatic logic last_phase(input logic [`IWDEC_PHASE_W-1:0] ph);
		last_phase = (ph == `IWDEC_PHASE_LAST);
	endfunction : last_phase

	// Skip outcome is judged in the last phase, when the datapath has its test result
	logic needs_second;
	always_comb begin
		needs_second = state_r.fields.is_branch || state_r.fields.is_return
			|| (state_r.fields.is_skip_test && i_test_true);
	end

	always_comb begin
		state_nxt = state_r;
		// Phase wraps from three back to zero on its own, so the sum is cut to the phase width
		state_nxt.phase = 2'(state_r.phase + 2'h1);
		state_nxt.cycle_start = last_phase(state_r.phase);
		if (last_phase(state_r.phase)) begin
			state_nxt.fields = split_fields;
			case (state_r.st)
				IWDEC_ST_EXEC: begin
					if (needs_second && !state_r.flush) begin
						state_nxt.st = IWDEC_ST_FLUSH;
						state_nxt.flush = 1'b1;
						state_nxt.pc_change = state_r.fields.is_branch || state_r.fields.is_return;
					end else begin
						state_nxt.flush = 1'b0;
						state_nxt.pc_change = 1'b0;
					end
				end
				IWDEC_ST_FLUSH: begin
					// A flushed word never triggers its own second cycle
					state_nxt.st = IWDEC_ST_EXEC;
					state_nxt.flush = 1'b0;
					state_nxt.pc_change = 1'b0;
				end
				default: begin
					state_nxt.st = IWDEC_ST_EXEC;
					state_nxt.flush = 1'b0;
					state_nxt.pc_change = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			state_r <= '{phase: `IWDEC_PHASE_RESET, st: IWDEC_ST_EXEC, fields: '0,
				flush: 1'b0, pc_change: 1'b0, cycle_start: 1'b0};
		end else begin
			state_r <= state_nxt;
		end
	end

	assign o_phase = state_r.phase;
	assign o_cycle_start = state_r.cycle_start;
	assign o_fields = state_r.fields;
	assign o_flush = state_r.flush;
	assign o_pc_change = state_r.pc_change;

	property p_phase_wraps;
		@(posedge i_clock) disable iff (!i_rstn)
		last_phase(o_phase) |=> o_phase == `IWDEC_PHASE_RESET && o_cycle_start;
	endproperty
	a_phase_wraps: assert property (p_phase_wraps) else $error("phase did not wrap after four clocks");

	property p_cycle_period;
		@(posedge i_clock) disable iff (!i_rstn)
		o_cycle_start |=> !o_cycle_start [*3] ##1 o_cycle_start;
	endproperty
	a_cycle_period: assert property (p_cycle_period) else $error("instruction cycle not four clocks");

	property p_flush_after_branch;
		@(posedge i_clock) disable iff (!i_rstn)
		last_phase(o_phase) && o_fields.is_branch && !o_flush |=> o_flush && o_pc_change;
	endproperty
	a_flush_after_branch: assert property (p_flush_after_branch) else $error("branch did not flush");

	property p_flush_after_skip;
		@(posedge i_clock) disable iff (!i_rstn)
		last_phase(o_phase) && o_fields.is_skip_test && i_test_true && !o_flush |=> o_flush && !o_pc_change;
	endproperty
	a_flush_after_skip: assert property (p_flush_after_skip) else $error("taken skip did not flush");

	property p_single_cycle;
		@(posedge i_clock) disable iff (!i_rstn)
		last_phase(o_phase) && !needs_second |=> !o_flush;
	endproperty
	a_single_cycle: assert property (p_single_cycle) else $error("plain instruction flushed");

	property p_flush_one_cycle;
		@(posedge i_clock) disable iff (!i_rstn)
		$rose(o_flush) |-> o_flush [*4] ##1 !o_flush;
	endproperty
	a_flush_one_cycle: assert property (p_flush_one_cycle) else $error("flush not exactly one cycle");

	property p_flush_state;
		@(posedge i_clock) disable iff (!i_rstn)
		o_flush == (state_r.st == IWDEC_ST_FLUSH);
	endproperty
	a_flush_state: assert property (p_flush_state) else $error("flush flag and state disagree");

	property p_fields_loaded;
		@(posedge i_clock) disable iff (!i_rstn)
		last_phase(o_phase) |=> o_fields.file_addr == $past(i_instr_word[`IWDEC_ADDR_HI:0])
			&& o_fields.lit11 == $past(i_instr_word[`IWDEC_LIT11_W-1:0]);
	endproperty
	a_fields_loaded: assert property (p_fields_loaded) else $error("operand fields not loaded");

	property p_class_map;
		@(posedge i_clock) disable iff (!i_rstn)
		last_phase(o_phase) && i_instr_word[`IWDEC_GROUP_HI:`IWDEC_GROUP_LO] == `IWDEC_GROUP_BIT
			|=> o_fields.op_class == IWDEC_CLASS_BIT;
	endproperty
	a_class_map: assert property (p_class_map) else $error("bit word misclassified");

	property p_reset_clear;
		@(posedge i_clock) $rose(i_rstn) |-> !o_flush [*4];
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("flush pending after reset");

	// Operands stand for the whole instruction cycle so the datapath may sample them in any phase
	property p_fields_stand;
		@(posedge i_clock) disable iff (!i_rstn)
		!last_phase(o_phase) |=> $stable(o_fields) && $stable(o_flush) && $stable(o_pc_change);
	endproperty
	a_fields_stand: assert property (p_fields_stand) else $error("decoded outputs changed inside a cycle");

	property p_pc_with_flush;
		@(posedge i_clock) disable iff (!i_rstn)
		o_pc_change |-> o_flush;
	endproperty
	a_pc_with_flush: assert property (p_pc_with_flush) else $error("counter change without flush");

	property p_dest_bit;
		@(posedge i_clock) disable iff (!i_rstn)
		last_phase(o_phase) |=> o_fields.dest_file == $past(i_instr_word[`IWDEC_DEST_BIT]);
	endproperty
	a_dest_bit: assert property (p_dest_bit) else $error("destination select not loaded");

	property p_bit_sel;
		@(posedge i_clock) disable iff (!i_rstn)
		last_phase(o_phase) |=> o_fields.bit_sel == $past(i_instr_word[`IWDEC_BITSEL_HI:`IWDEC_BITSEL_LO]);
	endproperty
	a_bit_sel: assert property (p_bit_sel) else $error("bit selector not loaded");

	property p_lit8;
		@(posedge i_clock) disable iff (!i_rstn)
		last_phase(o_phase) |=> o_fields.lit8 == $past(i_instr_word[`IWDEC_LIT8_W-1:0]);
	endproperty
	a_lit8: assert property (p_lit8) else $error("data literal not loaded");

	property p_byte_class;
		@(posedge i_clock) disable iff (!i_rstn)
		last_phase(o_phase) && i_instr_word[`IWDEC_GROUP_HI:`IWDEC_GROUP_LO] == `IWDEC_GROUP_BYTE
			|=> o_fields.op_class == IWDEC_CLASS_BYTE && !o_fields.is_branch;
	endproperty
	a_byte_class: assert property (p_byte_class) else $error("byte word misclassified");

	property p_branch_class;
		@(posedge i_clock) disable iff (!i_rstn)
		last_phase(o_phase) && i_instr_word[`IWDEC_GROUP_HI:`IWDEC_GROUP_LO] == `IWDEC_GROUP_BRANCH
			|=> o_fields.op_class == IWDEC_CLASS_LIT && o_fields.is_branch
			&& o_fields.is_call == !$past(i_instr_word[`IWDEC_JUMP_BIT]);
	endproperty
	a_branch_class: assert property (p_branch_class) else $error("call or jump misdecoded");

	// A word shown in a flushed cycle never ran, so it may not start a second cycle of its own
	property p_no_self_flush;
		@(posedge i_clock) disable iff (!i_rstn)
		last_phase(o_phase) && o_flush |=> !o_flush;
	endproperty
	a_no_self_flush: assert property (p_no_self_flush) else $error("flushed word started a flush");

	c_branch: cover property (@(posedge i_clock) disable iff (!i_rstn) o_pc_change);
	c_skip: cover property (@(posedge i_clock) disable iff (!i_rstn) o_flush && !o_pc_change);
	c_call: cover property (@(posedge i_clock) disable iff (!i_rstn) o_fields.is_call && o_cycle_start);
	c_return: cover property (@(posedge i_clock) disable iff (!i_rstn) o_fields.is_return && o_cycle_start);
	c_refused: cover property (@(posedge i_clock) disable iff (!i_rstn)
		last_phase(o_phase) && o_flush && o_fields.is_skip_test && i_test_true);
endmodule : iwdec_core
`default_nettype wire

// ### tb/iwdec_prog_mem.sv
// Program memory model: presents the stored word at the fetch index
`timescale 1ns/1ns
`default_nettype none
`include "iwdec_regs.svh"
module iwdec_prog_mem (
	input wire logic [3:0] i_index,
	output logic [`IWDEC_WORD_W-1:0] o_word
);
	logic [`IWDEC_WORD_W-1:0] mem_r [16];
	// Held while the index stands, so the word is valid at the sampling edge
	assign o_word = mem_r[i_index];
	initial begin
		mem_r = '{14'h0785, 14'h0B7F, 14'h1680, 14'h2ABC, 14'h1D23, 14'h3CFF, 14'h2123, 14'h0008,
			14'h0009, 14'h3000, 14'h3455, 14'h0F10, 14'h1900, 14'h3F12, 14'h2800, 14'h0000};
	end
endmodule : iwdec_prog_mem
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench for the instruction word decoder
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import iwdec_pkg::*;
	logic clock, rstn, test_true, cstart, flush, pcchg;
	logic [3:0] idx;
	logic [13:0] word;
	logic [1:0] phase;
	iwdec_fields_t fields;
	int err_total, samples_checked;
	// Per row: test result, expected flush, expected counter change
	logic [2:0] rows [14] = '{3'h0, 3'h4, 3'h2, 3'h0, 3'h7, 3'h0, 3'h0, 3'h3, 3'h0, 3'h3, 3'h0, 3'h3, 3'h4, 3'h2};
	iwdec_prog_mem i_mem (.i_index(idx), .o_word(word));
	iwdec_core i_dut (.i_clock(clock), .i_rstn(rstn), .i_instr_word(word), .i_test_true(test_true),
		.o_phase(phase), .o_cycle_start(cstart), .o_fields(fields), .o_flush(flush), .o_pc_change(pcchg));
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	task automatic chk(input logic ok, input string msg);
		samples_checked++;
		if (ok !== 1'b1) begin
			err_total++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask : chk
	task automatic final_report();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : final_report
	// Waits for phase 2, then presents the word for the coming sampling edge
	task automatic fetch(input logic [3:0] i, input logic t);
		int n;
		n = 0;
		do begin
			@(negedge clock);
			n++;
		end while (phase !== 2'h2 && n < 8);
		@(posedge clock);
		idx <= i;
		test_true <= t;
		n = 0;
		do begin
			@(negedge clock);
			n++;
		end while (cstart !== 1'b1 && n < 8);
		chk(n == 2 && phase === 2'h0, "cycle start spacing");
	endtask : fetch
	task automatic chk_fields();
		logic [13:0] w;
		logic skip_exp, ret_exp;
		w = word;
		skip_exp = (w[13:12] == 2'h0) ? ((w[11:8] == 4'hB) || (w[11:8] == 4'hF)) : (w[13:11] == 3'h3);
		ret_exp = (w == 14'h0008) || (w == 14'h0009) || (w[13:10] == 4'hD);
		chk(fields.op_class === (w[13:12] == 2'h0 ? IWDEC_CLASS_BYTE : w[13:12] == 2'h1 ? IWDEC_CLASS_BIT
			: IWDEC_CLASS_LIT), "class");
		chk(fields.file_addr === w[6:0] && fields.dest_file === w[7], "file fields");
		chk(fields.bit_sel === w[9:7] && fields.opcode === w[13:8], "bit fields");
		chk(fields.lit8 === w[7:0] && fields.lit11 === w[10:0], "literals");
		chk(fields.is_branch === (w[13:12] == 2'h2) && fields.is_call === (w[13:11] == 3'h4), "branch");
		chk(fields.is_skip_test === skip_exp && fields.skip_on_set === (w[13:10] == 4'h7), "skip");
		chk(fields.is_return === ret_exp, "return decode");
	endtask : chk_fields
	initial begin
		rstn = 1'b0;
		idx = 4'hF;
		test_true = 1'b0;
		repeat (16) @(posedge clock);
		rstn <= 1'b1;
		for (int i = 0; i < 14; i++) begin
			fetch(i[3:0], i > 0 ? rows[i-1][2] : 1'b0);
			chk_fields();
			chk(flush === rows[i][1] && pcchg === rows[i][0], "flush");
		end
		$display("test rows done");
		fetch(4'hE, 1'b0);
		fetch(4'hF, 1'b0);
		chk(flush === 1'b1, "flush after jump");
		// Reset lands while a jump still waits for its second cycle
		fetch(4'hE, 1'b0);
		chk(flush === 1'b0 && fields.is_branch === 1'b1, "jump pending before reset");
		@(posedge clock);
		rstn <= 1'b0;
		@(negedge clock);
		chk(phase === 2'h0 && cstart === 1'b0 && flush === 1'b0 && pcchg === 1'b0, "reset outputs");
		chk(fields === '0, "reset fields");
		@(posedge clock);
		rstn <= 1'b1;
		fetch(4'hF, 1'b0);
		chk(flush === 1'b0 && pcchg === 1'b0, "no flush after reset");
		$display("test reset done");
		final_report();
	end
	// The whole sequence needs some 23 instruction cycles; the limit leaves a wide margin
	initial begin
		#8000;
		err_total++;
		final_report();
	end
endmodule : tb_top
`default_nettype wire
